// *** gpd_pkg.sv ***
package gpd_pkg;

   // ----------------------------------------
   // register map (byte addresses, one register per offset)
   // ----------------------------------------
   localparam logic [3:0] GPD_ADDR_PIN_VALUE = 4'h0;
   localparam logic [3:0] GPD_ADDR_OUTPUT_LATCH = 4'h1;
   localparam logic [3:0] GPD_ADDR_DIRECTION = 4'h2;
   localparam logic [3:0] GPD_ADDR_PAD_CONFIG = 4'h3;
   localparam logic [3:0] GPD_ADDR_OPEN_DRAIN = 4'h4;
   localparam logic [3:0] GPD_ADDR_MODE_CONTROL = 4'h5;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int GPD_PULLUP_CONTROL_BIT = 7;
   localparam int GPD_SERIAL2_OPEN_DRAIN_BIT = 0;
   localparam int GPD_EXT_BUS_DISABLE_BIT = 7;
   localparam int GPD_SLAVE_PORT_MODE_BIT = 4;
   localparam int GPD_PULSE_GEN_ENABLE_BIT = 0;
   localparam int GPD_PIN_PULSE = 0;
   localparam int GPD_PIN_TIMER_IN = 1;
   localparam int GPD_PIN_SDO = 4;
   localparam int GPD_PIN_SDA = 5;
   localparam int GPD_PIN_SCK = 6;
   localparam int GPD_PIN_SELECT = 7;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] GPD_RST_LATCH = 8'h00;
   localparam logic [7:0] GPD_RST_DIRECTION = 8'hFF;
   // pull-up control set means pull-ups off
   localparam logic [7:0] GPD_RST_PAD_CONFIG = 8'h80;
   localparam logic [7:0] GPD_RST_OPEN_DRAIN = 8'h00;
   localparam logic [7:0] GPD_RST_MODE_CONTROL = 8'h00;
   localparam logic [7:0] GPD_PAD_CONFIG_MASK = 8'h80;
   localparam logic [7:0] GPD_OPEN_DRAIN_MASK = 8'h01;
   localparam logic [7:0] GPD_MODE_CONTROL_MASK = 8'h01;

   // ----------------------------------------
   // pin owner
   // ----------------------------------------
   typedef enum logic [1:0] {
      GPD_OWN_PORT = 2'b00,
      GPD_OWN_EXT_BUS = 2'b01,
      GPD_OWN_SLAVE_PORT = 2'b10
   } gpd_owner_type;

endpackage : gpd_pkg

// *** gpd_sync2.sv ***
`timescale 1ns/1ps
module gpd_sync2 (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // data
   input wire logic [7:0] i_async,
   output logic [7:0] o_sync
);
   import gpd_pkg::*;

   logic [7:0] meta_reg;
   logic [7:0] sync_reg;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meta_reg <= 8'h00;
         sync_reg <= 8'h00;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule : gpd_sync2

// *** gpd_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - eight pins, each with latch bit, direction bit and readable input bit.
// - direction 0 drives latch onto pin; direction 1 makes pin an input.
// - every reset leaves all eight pins as inputs while the port, not external bus or slave port, owns them.
// - one pad config bit 7 turns all pull-ups off when set.
// - pull-up forced off on any pin configured as an output.
// - every reset disables all weak pull-ups.
// - on large variant, port functions only while external bus disable is set.
// - external bus enabled: pins carry address/data low byte, direction overridden.
// - slave port mode bit turns pins into eight-bit slave data port, TTL inputs.
// - slave data port only in microcontroller mode, not external program memory.
// - serial pins 4 to 6 go open-drain when serial2 open-drain bit set.
// - serial clock output on bit 6 takes priority over port latch data.
// - data out bit 4, data in/i2c data bit 5, clock bit 6, select bit 7.
// - bit 0 carries pulse output; bit 1 feeds timer five clock, timer seven gate.
// - slave port, external bus and pulse functions set direction themselves.
module gpd_port (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // device level controls
   input wire logic i_large_variant,
   input wire logic i_ext_bus_disable,
   input wire logic i_micro_mode,
   input wire logic i_slave_port_mode,
   // external bus low byte
   input wire logic [7:0] i_ext_bus_out,
   input wire logic i_ext_bus_drive,
   output logic [7:0] o_ext_bus_in,
   // parallel slave port data
   input wire logic [7:0] i_slave_out,
   input wire logic i_slave_drive,
   output logic [7:0] o_slave_in,
   output logic o_slave_ttl,
   // sync serial module
   input wire logic i_serial2_data_out,
   input wire logic i_serial2_data_out_en,
   input wire logic i_serial2_clock_out,
   input wire logic i_serial2_clock_out_en,
   input wire logic i_i2c2_data_out,
   input wire logic i_i2c2_data_out_en,
   output logic o_serial2_data_in,
   output logic o_serial2_clock_in,
   output logic o_serial2_select,
   // pulse generator and timers
   input wire logic i_pulse_gen_out,
   output logic o_timer_five_clock_in,
   output logic o_timer_seven_gate_in,
   // pins
   input wire logic [7:0] i_pin,
   output logic [7:0] o_pin,
   output logic [7:0] o_pin_oe,
   output logic [7:0] o_pullup_en
);
   import gpd_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] latch_reg;
   logic [7:0] dir_reg;
   logic [7:0] pad_reg;
   logic [7:0] od_reg;
   logic [7:0] mode_reg;
   logic [7:0] rdata_reg;
   logic [7:0] pin_sync;
   gpd_owner_type owner;
   logic port_usable;
   logic [7:0] drv_val;
   logic [7:0] drv_en;
   logic [7:0] port_drv_val;
   logic [7:0] port_drv_en;
   logic [7:0] rdata_next;
   logic wr_latch;
   logic wr_dir;
   logic wr_pad;
   logic wr_od;
   logic wr_mode;

   gpd_sync2 u_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_async(i_pin),
      .o_sync(pin_sync)
   );

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   // both pin value and latch addresses land in the latch
   assign wr_latch = i_wr
      && (i_addr == GPD_ADDR_PIN_VALUE || i_addr == GPD_ADDR_OUTPUT_LATCH);
   assign wr_dir = i_wr && (i_addr == GPD_ADDR_DIRECTION);
   assign wr_pad = i_wr && (i_addr == GPD_ADDR_PAD_CONFIG);
   assign wr_od = i_wr && (i_addr == GPD_ADDR_OPEN_DRAIN);
   assign wr_mode = i_wr && (i_addr == GPD_ADDR_MODE_CONTROL);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         latch_reg <= GPD_RST_LATCH;
      end else if (wr_latch) begin
         latch_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         dir_reg <= GPD_RST_DIRECTION;
      end else if (wr_dir) begin
         dir_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pad_reg <= GPD_RST_PAD_CONFIG;
      end else if (wr_pad) begin
         pad_reg <= i_wdata & GPD_PAD_CONFIG_MASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         od_reg <= GPD_RST_OPEN_DRAIN;
      end else if (wr_od) begin
         od_reg <= i_wdata & GPD_OPEN_DRAIN_MASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mode_reg <= GPD_RST_MODE_CONTROL;
      end else if (wr_mode) begin
         mode_reg <= i_wdata & GPD_MODE_CONTROL_MASK;
      end
   end

   // ----------------------------------------
   // read port: data in the cycle after the strobe
   // ----------------------------------------
   // zero outside the answer cycle, so a stale value never looks like a read
   always_comb begin
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            GPD_ADDR_PIN_VALUE: rdata_next = pin_sync;
            GPD_ADDR_OUTPUT_LATCH: rdata_next = latch_reg;
            GPD_ADDR_DIRECTION: rdata_next = dir_reg;
            GPD_ADDR_PAD_CONFIG: rdata_next = pad_reg;
            GPD_ADDR_OPEN_DRAIN: rdata_next = od_reg;
            GPD_ADDR_MODE_CONTROL: rdata_next = mode_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

   // ----------------------------------------
   // pin ownership
   // ----------------------------------------
   // the small variant has no external bus, so the port is always usable there
   assign port_usable = !i_large_variant || i_ext_bus_disable;

   always_comb begin
      if (!port_usable) begin
         owner = GPD_OWN_EXT_BUS;
      end else if (i_slave_port_mode && i_micro_mode) begin
         owner = GPD_OWN_SLAVE_PORT;
      end else begin
         owner = GPD_OWN_PORT;
      end
   end

   assign o_slave_ttl = (owner == GPD_OWN_SLAVE_PORT);

   // ----------------------------------------
   // per-pin drive selection
   // ----------------------------------------
   for (genvar b = 0; b < 8; b++) begin : g_pin
      logic serial_en;
      logic serial_val;
      logic pulse_pin;
      logic od_pin;
      logic port_val;
      logic port_en;

      // which serial output, if any, may borrow this pin
      assign serial_en = (b == GPD_PIN_SDO) ? i_serial2_data_out_en
         : (b == GPD_PIN_SDA) ? i_i2c2_data_out_en
         : (b == GPD_PIN_SCK) ? i_serial2_clock_out_en
         : 1'b0;
      assign serial_val = (b == GPD_PIN_SDO) ? i_serial2_data_out
         : (b == GPD_PIN_SDA) ? i_i2c2_data_out
         : i_serial2_clock_out;
      assign pulse_pin = (b == GPD_PIN_PULSE) && mode_reg[GPD_PULSE_GEN_ENABLE_BIT];
      assign od_pin = (b >= GPD_PIN_SDO) && (b <= GPD_PIN_SCK)
         && od_reg[GPD_SERIAL2_OPEN_DRAIN_BIT];

      // port owner: the latch, unless a peripheral outranks it on this pin
      always_comb begin
         port_val = latch_reg[b];
         port_en = !dir_reg[b];
         if (pulse_pin) begin
            port_val = i_pulse_gen_out;
            port_en = 1'b1;
         end else if (serial_en && !dir_reg[b]) begin
            port_val = serial_val;
         end
         // open drain: drive only the low level, the board pulls high
         if (od_pin && port_val) begin
            port_en = 1'b0;
         end
      end

      assign port_drv_val[b] = port_val;
      assign port_drv_en[b] = port_en;
   end

   // a function that owns the whole byte sets the direction itself
   always_comb begin
      drv_val = port_drv_val;
      drv_en = port_drv_en;
      case (owner)
         GPD_OWN_EXT_BUS: begin
            drv_val = i_ext_bus_out;
            drv_en = {8{i_ext_bus_drive}};
         end
         GPD_OWN_SLAVE_PORT: begin
            drv_val = i_slave_out;
            drv_en = {8{i_slave_drive}};
         end
         GPD_OWN_PORT: begin
            drv_val = port_drv_val;
            drv_en = port_drv_en;
         end
         default: begin
            drv_val = latch_reg;
            drv_en = 8'h00;
         end
      endcase
   end

   assign o_pin = drv_val;
   assign o_pin_oe = drv_en;

   // pull-ups: off if control set, if the external bus owns the port, or if the pin drives for any function;
   // a peripheral that drives with its direction bit still set must not fight a pull-up
   assign o_pullup_en = (pad_reg[GPD_PULLUP_CONTROL_BIT] || !port_usable) ? 8'h00
      : (dir_reg & ~drv_en);

   // ----------------------------------------
   // inputs to peripherals
   // ----------------------------------------
   assign o_ext_bus_in = pin_sync;
   assign o_slave_in = pin_sync;
   assign o_serial2_data_in = pin_sync[GPD_PIN_SDA];
   assign o_serial2_clock_in = pin_sync[GPD_PIN_SCK];
   assign o_serial2_select = pin_sync[GPD_PIN_SELECT];
   assign o_timer_five_clock_in = pin_sync[GPD_PIN_TIMER_IN];
   assign o_timer_seven_gate_in = pin_sync[GPD_PIN_TIMER_IN];

endmodule : gpd_port

// *** gpd_board.sv ***
`timescale 1ns/1ps
// ----
// board side of the eight pins
// ----
module gpd_board (
   // clock
   input wire logic i_clk,
   // device pads
   input wire logic [7:0] i_pad_out,
   input wire logic [7:0] i_pad_oe,
   input wire logic [7:0] i_pullup,
   // external driver
   input wire logic [7:0] i_ext_val,
   input wire logic i_ext_en,
   output logic [7:0] o_level
);
   logic [7:0] last_reg = 8'h00;
   // a floating pin flips each cycle so a stale level never reads as a match
   always_ff @(posedge i_clk) begin
      last_reg <= ~last_reg;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         o_level[i] = i_pad_oe[i] ? i_pad_out[i] :
            (i_ext_en ? i_ext_val[i] : (i_pullup[i] | ~last_reg[i]));
      end
   end
endmodule : gpd_board

// *** gpd_port_monitor.sv ***
`timescale 1ns/1ps
// ----
// port checks
// ----
module gpd_port_monitor import gpd_pkg::*; (
   // inputs
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_large_variant,
   input wire logic i_ext_bus_disable,
   input wire logic i_micro_mode,
   input wire logic i_slave_port_mode,
   input wire logic i_ext_bus_drive,
   input wire logic i_slave_drive,
   input wire logic i_serial2_clock_out,
   input wire logic i_serial2_clock_out_en,
   input wire logic [7:0] i_pin,
   // outputs
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_pin,
   input wire logic [7:0] o_pin_oe,
   input wire logic [7:0] o_pullup_en,
   input wire logic o_slave_ttl,
   input wire logic o_timer_five_clock_in
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   logic bus_own;
   logic own;
   assign bus_own = i_large_variant && !i_ext_bus_disable;
   assign own = !bus_own && !(i_slave_port_mode && i_micro_mode);
   AST_PU_OFF_OUT: assert property ((o_pin_oe & o_pullup_en) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_RST_IN: assert property ($past(i_srst) && own |-> (o_pin_oe | o_pullup_en) == 8'h00)
      else $error("pins not released by reset");
   AST_PU_CTRL: assert property (i_wr && i_addr == GPD_ADDR_PAD_CONFIG && i_wdata[7]
      |=> o_pullup_en == 8'h00)
      else $error("pull-ups on after control set");
   AST_DIR: assert property (i_wr && i_addr == GPD_ADDR_DIRECTION ##1 own
      |-> o_pin_oe[3:2] == ~$past(i_wdata[3:2]))
      else $error("direction not applied");
   AST_EXT_BUS: assert property (bus_own
      |-> o_pin_oe == {8{i_ext_bus_drive}} && o_pullup_en == 8'h00)
      else $error("external bus not in charge");
   AST_SLAVE: assert property (!bus_own && i_slave_port_mode && i_micro_mode
      |-> o_slave_ttl && o_pin_oe == {8{i_slave_drive}})
      else $error("slave port not in charge");
   AST_SLAVE_MICRO: assert property (!i_micro_mode |-> !o_slave_ttl)
      else $error("slave port outside micro mode");
   AST_CLK_PRIO: assert property (own && i_serial2_clock_out_en && o_pin_oe[6]
      |-> o_pin[6] == i_serial2_clock_out)
      else $error("serial clock lost to latch");
   AST_TIMER_IN: assert property (!$past(i_srst) && !$past(i_srst, 2)
      |-> o_timer_five_clock_in == $past(i_pin[1], 2))
      else $error("timer input not pin one");
   AST_PIN_RD: assert property (i_rd && i_addr == GPD_ADDR_PIN_VALUE && !$past(i_srst)
      && !$past(i_srst, 2) |=> o_rdata == $past(i_pin, 3))
      else $error("pin read wrong");
endmodule : gpd_port_monitor
bind gpd_port gpd_port_monitor u_mon (.*);

// *** gpd_port_bench.sv ***
`timescale 1ns/1ps
// ----
// port bench
// ----
module gpd_port_bench;
   import gpd_pkg::*;
   logic i_clk = 1'h0;
   logic i_srst = 1'h1;
   logic wr_s = 1'h0, rd_s = 1'h0, lv = 1'h0, ebd = 1'h0, mm = 1'h1, spm = 1'h0;
   logic bd = 1'h0, sd = 1'h0, ck = 1'h0, cke = 1'h0, pg = 1'h0, ee = 1'h0, ttl, t5, t7;
   logic sdo = 1'h0, sdoe = 1'h0, sda = 1'h0, sdae = 1'h0, sdi, sci, ssl;
   logic [7:0] ebi, sli;
   logic [3:0] adr = 4'h0;
   logic [7:0] wd = 8'h00, ev = 8'h00, bo = 8'h00, rdat, pin, po, oe, pu, d;
   logic [3:0] ra [6] = '{GPD_ADDR_OUTPUT_LATCH, GPD_ADDR_DIRECTION, GPD_ADDR_PAD_CONFIG,
      GPD_ADDR_OPEN_DRAIN, GPD_ADDR_MODE_CONTROL, 4'hF};
   logic [7:0] rv [6] = '{8'h00, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h00};
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   always #20 i_clk = ~i_clk;
   gpd_board board (.i_clk(i_clk), .i_pad_out(po), .i_pad_oe(oe), .i_pullup(pu),
      .i_ext_val(ev), .i_ext_en(ee), .o_level(pin));
   gpd_port dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(adr), .i_wdata(wd), .i_wr(wr_s),
      .i_rd(rd_s), .o_rdata(rdat), .i_large_variant(lv), .i_ext_bus_disable(ebd),
      .i_micro_mode(mm), .i_slave_port_mode(spm), .i_ext_bus_out(bo), .i_ext_bus_drive(bd),
      .o_ext_bus_in(ebi), .i_slave_out(bo), .i_slave_drive(sd), .o_slave_in(sli),
      .o_slave_ttl(ttl), .i_serial2_data_out(sdo), .i_serial2_data_out_en(sdoe),
      .i_serial2_clock_out(ck), .i_serial2_clock_out_en(cke), .i_i2c2_data_out(sda),
      .i_i2c2_data_out_en(sdae), .o_serial2_data_in(sdi), .o_serial2_clock_in(sci),
      .o_serial2_select(ssl),
      .i_pulse_gen_out(pg), .o_timer_five_clock_in(t5), .o_timer_seven_gate_in(t7),
      .i_pin(pin), .o_pin(po), .o_pin_oe(oe), .o_pullup_en(pu));
   task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic wr(logic [3:0] a, logic [7:0] v);
      @(posedge i_clk);
      adr <= a;
      wd <= v;
      wr_s <= 1'h1;
      @(posedge i_clk);
      wr_s <= 1'h0;
      #1;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge i_clk);
      adr <= a;
      rd_s <= 1'h1;
      @(posedge i_clk);
      rd_s <= 1'h0;
      #1;
      d = rdat;
   endtask : rd
   task automatic tk(int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tk
   task automatic close_out;
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'h0;
      tk(1);
      cmp("oe_rst", 8'h00, oe | pu);
      foreach (ra[k]) begin
         rd(ra[k]);
         cmp("reg_rst", rv[k], d);
      end
      wr(GPD_ADDR_PAD_CONFIG, 8'h00);
      cmp("pu_on", 8'hFF, pu);
      wr(GPD_ADDR_DIRECTION, 8'h0F);
      cmp("oe_dir", 8'hF0, oe);
      cmp("pu_out", 8'h0F, pu);
      wr(GPD_ADDR_PIN_VALUE, 8'hA5);
      cmp("pin_out", 8'hA0, po & 8'hF0);
      rd(GPD_ADDR_OUTPUT_LATCH);
      cmp("latch", 8'hA5, d);
      wr(GPD_ADDR_PAD_CONFIG, 8'hFF);
      cmp("pu_off", 8'h00, pu);
      rd(GPD_ADDR_PAD_CONFIG);
      cmp("pad", 8'h80, d);
      wr(GPD_ADDR_DIRECTION, 8'hFF);
      @(posedge i_clk);
      ev <= 8'h96;
      ee <= 1'h1;
      tk(3);
      rd(GPD_ADDR_PIN_VALUE);
      cmp("pin_in", 8'h96, d);
      cmp("timer_in", 8'h03, {6'h00, t5, t7});
      cmp("bus_in", 8'h96, ebi);
      cmp("slave_in", 8'h96, sli);
      cmp("serial_in", 8'h04, {5'h00, ssl, sci, sdi});
      @(posedge i_clk);
      ee <= 1'h0;
      ck <= 1'h1;
      cke <= 1'h1;
      sdo <= 1'h1;
      sdoe <= 1'h1;
      sda <= 1'h1;
      sdae <= 1'h1;
      wr(GPD_ADDR_OUTPUT_LATCH, 8'h00);
      wr(GPD_ADDR_DIRECTION, 8'h8F);
      cmp("sck", 8'h01, {7'h00, po[6]});
      cmp("serial_out", 8'h07, {5'h00, po[6:4]});
      wr(GPD_ADDR_OPEN_DRAIN, 8'h01);
      cmp("od_high", 8'h00, {7'h00, oe[6]});
      @(posedge i_clk);
      ck <= 1'h0;
      tk(1);
      cmp("od_low", 8'h02, {6'h00, oe[6], po[6]});
      @(posedge i_clk);
      cke <= 1'h0;
      sdoe <= 1'h0;
      sdae <= 1'h0;
      pg <= 1'h1;
      wr(GPD_ADDR_DIRECTION, 8'hFF);
      wr(GPD_ADDR_MODE_CONTROL, 8'h01);
      cmp("pulse", 8'h03, {6'h00, oe[0], po[0]});
      wr(GPD_ADDR_MODE_CONTROL, 8'h00);
      wr(GPD_ADDR_PAD_CONFIG, 8'h00);
      @(posedge i_clk);
      lv <= 1'h1;
      bd <= 1'h1;
      bo <= 8'h5A;
      tk(1);
      cmp("bus", 8'h5A, po & oe);
      cmp("bus_pu", 8'h00, pu);
      @(posedge i_clk);
      ebd <= 1'h1;
      tk(1);
      cmp("port_pu", 8'hFF, pu);
      @(posedge i_clk);
      lv <= 1'h0;
      spm <= 1'h1;
      sd <= 1'h1;
      tk(1);
      cmp("slave", 8'hFF, {ttl, oe[6:0]});
      @(posedge i_clk);
      mm <= 1'h0;
      tk(1);
      cmp("slave_off", 8'h00, {ttl, oe[6:0]});
      @(posedge i_clk);
      spm <= 1'h0;
      mm <= 1'h1;
      wr(GPD_ADDR_DIRECTION, 8'h00);
      @(posedge i_clk);
      i_srst <= 1'h1;
      @(posedge i_clk);
      i_srst <= 1'h0;
      tk(1);
      cmp("oe_rst2", 8'h00, oe | pu);
      close_out();
   end
endmodule : gpd_port_bench
